// [design/uiq_params.svh]
// constants for the utility info query interpreter: offsets, reset values, codes
// assumes the including file knows nothing else about the block
`ifndef UIQ_PARAMS_SVH
`define UIQ_PARAMS_SVH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define UIQ_A_CFG    8'h00
`define UIQ_A_FILT   8'h04
`define UIQ_A_UNIT   8'h08
`define UIQ_A_FMT    8'h0C
`define UIQ_A_ISTAT  8'h10
`define UIQ_A_IMASK  8'h14
`define UIQ_A_LAST   8'h18

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define UIQ_CFG_VSTB  3
`define UIQ_CFG_BTO   4
`define UIQ_LAST_BUSY 8
`define UIQ_RST_AXES  3'h7
`define UIQ_RST_FILT  12'h444
`define UIQ_RST_UNIT  8'h41
`define UIQ_RST_FMT   8'h53
`define UIQ_IRQ_DONE  0
`define UIQ_IRQ_CERR  1
`define UIQ_IRQ_EERR  2

// ------------------------------------------------------------
// characters
// ------------------------------------------------------------
`define UIQ_CH_DOLLAR 8'h24
`define UIQ_CH_HASH   8'h23
`define UIQ_CH_COMMA  8'h2C
`define UIQ_CH_CR     8'h0D
`define UIQ_CH_ZERO   8'h30
`define UIQ_CH_NINE   8'h39
`define UIQ_CH_X      8'h58
`define UIQ_CH_LT     8'h74
`define UIQ_CH_LB     8'h62
`define UIQ_CASE_OFS  8'h20
`define UIQ_NA_STR    16'h4E41

// ------------------------------------------------------------
// status codes and field counts
// ------------------------------------------------------------
`define UIQ_ST_OK     4'h0
`define UIQ_ST_INVAL  4'h1
`define UIQ_ST_CRC    4'h2
`define UIQ_ST_UNK    4'h3
`define UIQ_ST_NPAR   4'h4
`define UIQ_ST_PAR    4'h5
`define UIQ_ERR_BYTES 10
`define UIQ_ERR_BITS  80
`define UIQ_NF_ERRQ   5'h11

`endif

// [design/uiq_pkg.sv]
// types shared by the utility info query interpreter
// assumes uiq_params.svh holds all numeric constants
package uiq_pkg;

  typedef enum logic [3:0] {C_NONE, C_IAX, C_ICONF, C_DGF, C_ERQ, C_IFW, C_IGF, C_IGU, C_IHW} uiq_cmd_t;

  typedef enum logic [2:0] {T_IDLE, T_HASH, T_CMD, T_SEP, T_FLD, T_CSUM, T_CR} uiq_txs_t;

  // one response field: up to eight characters, left justified
  typedef struct packed {
    logic [3:0]  len;
    logic [63:0] str;
  } uiq_fld_t;

endpackage

// [design/uiq_sum8.sv]
// modulo-256 character sum used as the line checksum
// assumes clr and add are synchronous one-cycle strobes
`timescale 1ns/10ps
module uiq_sum8 (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clr,
  input  wire logic       add,
  input  wire logic [7:0] din,
  output logic      [7:0] sum_q
);
  wire [7:0] base = clr ? 8'h00 : sum_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sum_q <= 8'h00;
    else if (clr || add) sum_q <= add ? base + din : base;
  end
endmodule // uiq_sum8

// [design/uiq_err_acc.sv]
// sticky accumulator for the extended error bits with snapshot-and-clear
// assumes set carries one-cycle error pulses
`timescale 1ns/10ps
`include "uiq_params.svh"
module uiq_err_acc (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [`UIQ_ERR_BITS-1:0] set,
  input  wire logic                     take,
  output logic      [`UIQ_ERR_BITS-1:0] snap_q
);
  logic [`UIQ_ERR_BITS-1:0] acc_q;

  // an error arriving with take is kept for the next report, never lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q  <= '0;
      snap_q <= '0;
    end else begin
      acc_q <= take ? set : (acc_q | set);
      if (take) snap_q <= acc_q;
    end
  end
endmodule // uiq_err_acc

// [design/uiq_top.sv]
// utility info query interpreter: parses ASCII query lines, builds responses
// assumes byte-wide receive/transmit streams from a serial controller
// What this block does
// RULE1 - each answer is '#', the command word, status, results, checksum and CR.
// RULE2 - the received command word is echoed right after '#', status 0 on success; the code echoes it only for status 0, 4 and 5.
// RULE3 - axis query returns configured axes letters or NA, then two NA fields.
// RULE4 - the host passes t with the config query to ask for strobe toggling.
// RULE5 - the host may pass b instead to ask about the bias trim datagram.
// RULE6 - config query echoes the argument in upper case then its value, 0 inactive.
// RULE7 - format query returns a one letter code, S for id-rate-checksum.
// RULE8 - error query returns ten decimal bytes MSB first then six 0 fields.
// RULE9 - reporting the error register clears it, keeping only new errors.
// RULE10 - firmware query returns one identity text field.
// RULE11 - filter query returns one code per axis X,Y,Z, NA when unconfigured.
// RULE12 - unit query returns a letter code, A for degrees per second.
// RULE13 - hardware query returns one identity text field.
// RULE14 - checksum is the 8-bit sum of all chars through the last comma, in decimal.
// RULE15 - with several errors only the lowest status code is reported.
// RULE16 - incoming checksums are checked with the same sum before executing.
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`include "uiq_params.svh"
module uiq_top #(
  parameter logic [63:0] FW_ID = 64'h4657_4346_472D_3031, // arbitrary value
  parameter logic [63:0] HW_ID = 64'h4857_4346_472D_3031  // arbitrary value
) (
  input  wire logic                     CLOCK,
  input  wire logic                     RSTN,
  input  wire logic [7:0]               RX_DATA,
  input  wire logic                     RX_VALID,
  output logic      [7:0]               TX_DATA,
  output logic                          TX_VALID,
  input  wire logic                     TX_READY,
  input  wire logic [`UIQ_ERR_BITS-1:0] ERR_IN,
  input  wire logic [7:0]               ADDR,
  input  wire logic [31:0]              WDATA,
  input  wire logic                     WR,
  input  wire logic                     RD,
  output logic      [31:0]              RDATA,
  output logic                          IRQ
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic uiq_pkg::uiq_fld_t num_fld(input logic [7:0] v);
    uiq_pkg::uiq_fld_t r;
    logic [7:0] h;
    logic [7:0] t;
    logic [7:0] o;
    h = v / 8'd100;
    t = (v / 8'd10) % 8'd10;
    o = v % 8'd10;
    r.str = '0;
    if (v >= 8'd100) begin
      r.len = 4'd3;
      r.str[63:40] = {`UIQ_CH_ZERO + h, `UIQ_CH_ZERO + t, `UIQ_CH_ZERO + o};
    end else if (v >= 8'd10) begin
      r.len = 4'd2;
      r.str[63:48] = {`UIQ_CH_ZERO + t, `UIQ_CH_ZERO + o};
    end else begin
      r.len = 4'd1;
      r.str[63:56] = `UIQ_CH_ZERO + o;
    end
    return r;
  endfunction

  function automatic uiq_pkg::uiq_fld_t chr_fld(input logic [7:0] c);
    return '{len: 4'd1, str: {c, 56'h0}};
  endfunction

  function automatic uiq_pkg::uiq_fld_t na_fld();
    return '{len: 4'd2, str: {`UIQ_NA_STR, 48'h0}};
  endfunction

  function automatic logic [7:0] chr_at(input logic [63:0] s, input logic [3:0] i);
    return s[8*(7-i) +: 8];
  endfunction

  function automatic uiq_pkg::uiq_cmd_t cmd_dec(input logic [39:0] w, input logic [2:0] n);
    uiq_pkg::uiq_cmd_t c;
    c = uiq_pkg::C_NONE;
    if (n == 3'd3 && w[23:0] == 24'h69_6178) c = uiq_pkg::C_IAX;
    if (n == 3'd5 && w == 40'h69_636F_6E66) c = uiq_pkg::C_ICONF;
    if (n == 3'd2 && w[15:0] == 16'h6964) c = uiq_pkg::C_DGF;
    if (n == 3'd2 && w[15:0] == 16'h6965) c = uiq_pkg::C_ERQ;
    if (n == 3'd3 && w[23:0] == 24'h69_6677) c = uiq_pkg::C_IFW;
    if (n == 3'd3 && w[23:0] == 24'h69_6766) c = uiq_pkg::C_IGF;
    if (n == 3'd3 && w[23:0] == 24'h69_6775) c = uiq_pkg::C_IGU;
    if (n == 3'd3 && w[23:0] == 24'h69_6877) c = uiq_pkg::C_IHW;
    return c;
  endfunction

  // ------------------------------------------------------------
  // receive side
  // ------------------------------------------------------------
  logic                 rx_act_q, dollar_q, go_q, nbad_q;
  logic [39:0]          word_q;
  logic [2:0]           wlen_q;
  logic [1:0]           ncomma_q, plen_q, nd_q;
  logic [7:0]           par_q, sum_lc_q;
  logic [9:0]           num_q;
  logic [7:0]           rx_sum;
  uiq_pkg::uiq_txs_t    txs_q;

  wire       busy    = (txs_q != uiq_pkg::T_IDLE) || go_q;
  wire       rx_take = RX_VALID && !busy; // lines arriving mid-answer are dropped
  wire       is_cr   = RX_DATA == `UIQ_CH_CR;
  wire       is_cm   = RX_DATA == `UIQ_CH_COMMA;
  wire       is_dg   = RX_DATA >= `UIQ_CH_ZERO && RX_DATA <= `UIQ_CH_NINE;
  wire       rx_new  = rx_take && !is_cr && !rx_act_q;
  wire       rx_more = rx_take && !is_cr && rx_act_q;
  wire [9:0] dig     = {6'h0, RX_DATA[3:0]};

  uiq_sum8 u_rx_sum (
    .clk   (CLOCK),
    .rst_n (RSTN),
    .clr   (rx_new),
    .add   (rx_take && !is_cr),
    .din   (RX_DATA),
    .sum_q (rx_sum)
  );

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rx_act_q <= 1'b0;
      dollar_q <= 1'b0;
      go_q     <= 1'b0;
      word_q   <= '0;
      wlen_q   <= '0;
      ncomma_q <= '0;
      plen_q   <= '0;
      nd_q     <= '0;
      nbad_q   <= 1'b1;
      par_q    <= '0;
      sum_lc_q <= '0;
      num_q    <= '0;
    end else begin
      go_q <= rx_take && is_cr && rx_act_q;
      if (rx_take && is_cr) rx_act_q <= 1'b0;
      if (rx_new) begin
        rx_act_q <= 1'b1;
        dollar_q <= RX_DATA == `UIQ_CH_DOLLAR;
        word_q   <= '0;
        wlen_q   <= '0;
        ncomma_q <= '0;
        plen_q   <= '0;
        nd_q     <= '0;
        nbad_q   <= 1'b1;
      end
      if (rx_more && is_cm) begin
        if (ncomma_q != 2'd3) ncomma_q <= ncomma_q + 2'd1;
        sum_lc_q <= rx_sum + `UIQ_CH_COMMA; // RULE14
        num_q    <= '0;
        nd_q     <= '0;
        nbad_q   <= 1'b1;
      end
      if (rx_more && !is_cm) begin
        if (ncomma_q == 2'd0) begin
          word_q <= {word_q[31:0], RX_DATA};
          if (wlen_q != 3'd7) wlen_q <= wlen_q + 3'd1;
        end
        if (ncomma_q == 2'd1) begin
          if (plen_q == 2'd0) par_q <= RX_DATA;
          if (plen_q != 2'd3) plen_q <= plen_q + 2'd1;
        end
        if (is_dg && nd_q != 2'd3) begin
          num_q  <= 10'(num_q * 10'd10) + dig;
          nd_q   <= nd_q + 2'd1;
          nbad_q <= 1'b0;
        end else begin
          nbad_q <= 1'b1; // non-digit or a fourth digit spoils the checksum
        end
      end
    end
  end

  // ------------------------------------------------------------
  // command decode and status
  // ------------------------------------------------------------
  uiq_pkg::uiq_cmd_t cmd_w;
  assign cmd_w = cmd_dec(word_q, wlen_q);

  wire       crc_ok  = ncomma_q != 2'd0 && !nbad_q && num_q == {2'b00, sum_lc_q}; // RULE16
  wire [1:0] exp_cm  = (cmd_w == uiq_pkg::C_ICONF) ? 2'd2 : 2'd1;
  wire       par_bad = cmd_w == uiq_pkg::C_ICONF &&
                       (plen_q != 2'd1 || (par_q != `UIQ_CH_LT && par_q != `UIQ_CH_LB)); // RULE4 RULE5
  wire [3:0] st_w    = !dollar_q                ? `UIQ_ST_INVAL : // RULE15
                       !crc_ok                  ? `UIQ_ST_CRC   :
                       cmd_w == uiq_pkg::C_NONE ? `UIQ_ST_UNK   :
                       ncomma_q != exp_cm       ? `UIQ_ST_NPAR  :
                       par_bad                  ? `UIQ_ST_PAR   : `UIQ_ST_OK;

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  logic [2:0]  axes_q, istat_q, imask_q;
  logic        vstb_q, bto_q;
  logic [11:0] filt_q;
  logic [7:0]  unit_q, fmt_q;
  logic [3:0]  last_q;
  logic [31:0] rd_mux;
  logic [`UIQ_ERR_BITS-1:0] snap;

  wire wr_cfg  = WR && ADDR == `UIQ_A_CFG;
  wire wr_filt = WR && ADDR == `UIQ_A_FILT;
  wire wr_unit = WR && ADDR == `UIQ_A_UNIT;
  wire wr_fmt  = WR && ADDR == `UIQ_A_FMT;
  wire wr_ist  = WR && ADDR == `UIQ_A_ISTAT;
  wire wr_imsk = WR && ADDR == `UIQ_A_IMASK;

  // ------------------------------------------------------------
  // response sequencer
  // ------------------------------------------------------------
  uiq_pkg::uiq_cmd_t cmd_q;
  uiq_pkg::uiq_fld_t fld, csf;
  logic [3:0] st_q, ci_q;
  logic [4:0] fi_q, nf_q;
  logic       echo_q;
  logic [7:0] tx_sum, tx_byte;

  wire slot    = !TX_VALID || TX_READY;
  wire tx_load = slot && txs_q != uiq_pkg::T_IDLE;
  wire tx_add  = tx_load && txs_q != uiq_pkg::T_CSUM && txs_q != uiq_pkg::T_CR;
  wire done    = tx_load && txs_q == uiq_pkg::T_CR;
  wire snap_go = go_q && st_w == `UIQ_ST_OK && cmd_w == uiq_pkg::C_ERQ; // RULE9
  wire [1:0] ax = 2'(fi_q - 5'd1);

  uiq_sum8 u_tx_sum (
    .clk   (CLOCK),
    .rst_n (RSTN),
    .clr   (go_q),
    .add   (tx_add),
    .din   (tx_byte),
    .sum_q (tx_sum)
  );

  uiq_err_acc u_err (
    .clk    (CLOCK),
    .rst_n  (RSTN),
    .set    (ERR_IN),
    .take   (snap_go),
    .snap_q (snap)
  );

  always_comb begin
    fld = chr_fld(`UIQ_CH_ZERO);
    if (fi_q == 5'd0) begin
      fld = num_fld({4'h0, st_q});
    end else begin
      unique case (cmd_q)
        uiq_pkg::C_NONE: ;
        uiq_pkg::C_IAX: begin
          fld = na_fld(); // RULE3
          if (fi_q == 5'd1 && axes_q != 3'h0) begin
            fld.len = 4'd0;
            fld.str = '0;
            for (int i = 0; i < 3; i++) begin
              if (axes_q[i]) begin
                fld.str[8*(7-fld.len) +: 8] = `UIQ_CH_X + 8'(i);
                fld.len = fld.len + 4'd1;
              end
            end
          end
        end
        uiq_pkg::C_ICONF: fld = (fi_q == 5'd1) ? chr_fld(par_q - `UIQ_CASE_OFS) : // RULE6
                                chr_fld(`UIQ_CH_ZERO + {7'h0, par_q == `UIQ_CH_LT ? vstb_q : bto_q});
        uiq_pkg::C_DGF:   fld = chr_fld(fmt_q); // RULE7
        uiq_pkg::C_ERQ:   if (fi_q <= 5'd10) fld = num_fld(snap[8*(`UIQ_ERR_BYTES-fi_q) +: 8]); // RULE8
        uiq_pkg::C_IFW:   fld = '{len: 4'd8, str: FW_ID}; // RULE10
        uiq_pkg::C_IGF:   fld = axes_q[ax] ? num_fld({4'h0, filt_q[4*ax +: 4]}) : na_fld(); // RULE11
        uiq_pkg::C_IGU:   fld = chr_fld(unit_q); // RULE12
        uiq_pkg::C_IHW:   fld = '{len: 4'd8, str: HW_ID}; // RULE13
      endcase
    end
  end

  assign csf = num_fld(tx_sum); // RULE14

  // RULE1
  assign tx_byte = txs_q == uiq_pkg::T_HASH ? `UIQ_CH_HASH :
                   txs_q == uiq_pkg::T_CMD  ? word_q[8*(wlen_q-3'd1-ci_q[2:0]) +: 8] :
                   txs_q == uiq_pkg::T_SEP  ? `UIQ_CH_COMMA :
                   txs_q == uiq_pkg::T_FLD  ? chr_at(fld.str, ci_q) :
                   txs_q == uiq_pkg::T_CSUM ? chr_at(csf.str, ci_q) : `UIQ_CH_CR;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      txs_q    <= uiq_pkg::T_IDLE;
      cmd_q    <= uiq_pkg::C_NONE;
      st_q     <= `UIQ_ST_OK;
      nf_q     <= 5'h0;
      echo_q   <= 1'b0;
      ci_q     <= 4'h0;
      fi_q     <= 5'h0;
      TX_VALID <= 1'b0;
      TX_DATA  <= 8'h00;
    end else begin
      if (slot) TX_VALID <= tx_load;
      if (tx_load) TX_DATA <= tx_byte;
      if (go_q) begin
        txs_q  <= uiq_pkg::T_HASH;
        cmd_q  <= (st_w == `UIQ_ST_OK) ? cmd_w : uiq_pkg::C_NONE;
        st_q   <= st_w;
        echo_q <= st_w == `UIQ_ST_OK || st_w >= `UIQ_ST_NPAR; // RULE2
        nf_q   <= st_w != `UIQ_ST_OK     ? 5'h1 :
                  cmd_w == uiq_pkg::C_IAX || cmd_w == uiq_pkg::C_IGF ? 5'h4 :
                  cmd_w == uiq_pkg::C_ICONF ? 5'h3 :
                  cmd_w == uiq_pkg::C_ERQ   ? `UIQ_NF_ERRQ : 5'h2;
        ci_q   <= 4'h0;
        fi_q   <= 5'h0;
      end else if (tx_load) begin
        unique case (txs_q)
          uiq_pkg::T_IDLE: ;
          uiq_pkg::T_HASH: txs_q <= echo_q ? uiq_pkg::T_CMD : uiq_pkg::T_SEP;
          uiq_pkg::T_CMD: begin
            ci_q <= (ci_q == {1'b0, wlen_q} - 4'd1) ? 4'h0 : ci_q + 4'd1;
            if (ci_q == {1'b0, wlen_q} - 4'd1) txs_q <= uiq_pkg::T_SEP;
          end
          uiq_pkg::T_SEP: txs_q <= (fi_q == nf_q) ? uiq_pkg::T_CSUM : uiq_pkg::T_FLD;
          uiq_pkg::T_FLD: begin
            ci_q <= (ci_q == fld.len - 4'd1) ? 4'h0 : ci_q + 4'd1;
            if (ci_q == fld.len - 4'd1) begin
              txs_q <= uiq_pkg::T_SEP;
              fi_q  <= fi_q + 5'd1;
            end
          end
          uiq_pkg::T_CSUM: begin
            ci_q <= ci_q + 4'd1;
            if (ci_q == csf.len - 4'd1) txs_q <= uiq_pkg::T_CR;
          end
          uiq_pkg::T_CR: txs_q <= uiq_pkg::T_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // register bus and interrupt
  // ------------------------------------------------------------
  wire [2:0] ev      = {|ERR_IN, done && st_q != `UIQ_ST_OK, done};
  wire [2:0] istat_d = (istat_q & ~(wr_ist ? WDATA[2:0] : 3'h0)) | ev; // set wins over clear

  assign rd_mux = ADDR == `UIQ_A_CFG   ? {27'h0, bto_q, vstb_q, axes_q} :
                  ADDR == `UIQ_A_FILT  ? {20'h0, filt_q} :
                  ADDR == `UIQ_A_UNIT  ? {24'h0, unit_q} :
                  ADDR == `UIQ_A_FMT   ? {24'h0, fmt_q} :
                  ADDR == `UIQ_A_ISTAT ? {29'h0, istat_q} :
                  ADDR == `UIQ_A_IMASK ? {29'h0, imask_q} :
                  ADDR == `UIQ_A_LAST  ? {23'h0, busy, 4'h0, last_q} : 32'h0;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      axes_q  <= `UIQ_RST_AXES;
      vstb_q  <= 1'b0;
      bto_q   <= 1'b0;
      filt_q  <= `UIQ_RST_FILT;
      unit_q  <= `UIQ_RST_UNIT;
      fmt_q   <= `UIQ_RST_FMT;
      istat_q <= 3'h0;
      imask_q <= 3'h0;
      last_q  <= 4'h0;
      RDATA   <= 32'h0;
      IRQ     <= 1'b0;
    end else begin
      if (wr_cfg) {bto_q, vstb_q, axes_q} <= WDATA[`UIQ_CFG_BTO:0];
      if (wr_filt) filt_q <= WDATA[11:0];
      if (wr_unit) unit_q <= WDATA[7:0];
      if (wr_fmt) fmt_q <= WDATA[7:0];
      if (wr_imsk) imask_q <= WDATA[2:0];
      if (done) last_q <= st_q;
      istat_q <= istat_d;
      IRQ     <= |(istat_d & imask_q);
      RDATA   <= RD ? rd_mux : 32'h0;
    end
  end
endmodule // uiq_top

// [tb/uiq_host_model.sv]
// host side of the serial query line: sends command bytes, collects answer bytes
// assumes the bench builds complete lines and reads got_q hierarchically
`timescale 1ns/10ps
module uiq_host_model (
  input  wire logic       clk,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  logic [7:0] got_q [$];
  logic [1:0] cnt_q = 2'h0;
  logic       slow  = 1'b0;

  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end

  // ------------------------------------------------------------
  // answer sink: in slow mode ready is high one cycle in four
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cnt_q    <= cnt_q + 2'h1;
    tx_ready <= !slow || (cnt_q == 2'h3);
    if (tx_valid && tx_ready) begin
      got_q.push_back(tx_data);
    end
  end

  // ------------------------------------------------------------
  // command source: one-cycle byte pulses with a gap between them
  // ------------------------------------------------------------
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      rx_data  <= s[i];
      rx_valid <= 1'b1;
      @(posedge clk);
      rx_valid <= 1'b0;
      // a released line shows junk, never the last byte
      rx_data  <= ~s[i];
    end
  endtask
endmodule // uiq_host_model

// [tb/uiq_top_asserts.sv]
// port-level checks on the query interpreter
// assumes it is bound to uiq_top and sees only its ports
`timescale 1ns/10ps
`include "uiq_params.svh"
module uiq_top_asserts (
  input wire logic        CLOCK,
  input wire logic        RSTN,
  input wire logic [7:0]  RX_DATA,
  input wire logic        RX_VALID,
  input wire logic [7:0]  TX_DATA,
  input wire logic        TX_VALID,
  input wire logic        TX_READY,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  // ------------------------------------------------------------
  // answer stream
  // ------------------------------------------------------------
  tx_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("answer byte changed before it was taken");
  tx_open_a: assert property ($rose(TX_VALID) |-> TX_DATA == `UIQ_CH_HASH)
    else $error("answer did not open with hash");
  tx_close_a: assert property (TX_VALID && TX_READY && TX_DATA == `UIQ_CH_CR |=> !TX_VALID)
    else $error("answer went on after its carriage return");
  tx_cause_a: assert property ($rose(TX_VALID) |->
    ($past(RX_VALID, 2) && $past(RX_DATA, 2) == `UIQ_CH_CR) || ($past(RX_VALID, 3) && $past(RX_DATA, 3) == `UIQ_CH_CR))
    else $error("answer started without a closing carriage return");
  tx_text_a: assert property (TX_VALID |-> TX_DATA == `UIQ_CH_CR || (TX_DATA >= 8'h20 && TX_DATA <= 8'h7E))
    else $error("answer byte is not printable text");

  // ------------------------------------------------------------
  // register port and interrupt
  // ------------------------------------------------------------
  rd_idle_a: assert property (!RD |=> RDATA == 32'h0000_0000)
    else $error("read data present without a read");
  rd_unmap_a: assert property (RD && ADDR > `UIQ_A_LAST |=> RDATA == 32'h0000_0000)
    else $error("unmapped read returned data");
  irq_mask_a: assert property (WR && ADDR == `UIQ_A_IMASK && WDATA == 32'h0000_0000 |-> ##2 !IRQ)
    else $error("interrupt high with everything masked");
  rst_quiet_a: assert property ($rose(RSTN) |-> !IRQ && !TX_VALID && RDATA == 32'h0000_0000)
    else $error("outputs not quiet after reset");

  cover property ($rose(TX_VALID));
  cover property (TX_VALID && !TX_READY);
  cover property (RD && ADDR > `UIQ_A_LAST);
  cover property ($rose(IRQ));
endmodule // uiq_top_asserts

bind uiq_top uiq_top_asserts i_uiq_top_asserts (.CLOCK(CLOCK), .RSTN(RSTN), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
  .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .IRQ(IRQ));

// [tb/uiq_top_test.sv]
// self-checking bench for the utility info query interpreter
// assumes the host model drives the serial side and this module the register bus
`timescale 1ns/10ps
`include "uiq_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module uiq_top_test;
  logic                     CLOCK    = 1'b0;
  logic                     RSTN     = 1'b0;
  logic [7:0]               RX_DATA;
  logic                     RX_VALID;
  logic [7:0]               TX_DATA;
  logic                     TX_VALID;
  logic                     TX_READY;
  logic [`UIQ_ERR_BITS-1:0] ERR_IN   = '0;
  logic [7:0]               ADDR     = 8'h00;
  logic [31:0]              WDATA    = 32'h0000_0000;
  logic                     WR       = 1'b0;
  logic                     RD       = 1'b0;
  logic [31:0]              RDATA;
  logic                     IRQ;
  logic [31:0]              d;
  int                       num_errors  = 0;
  int                       check_count = 0;
  int                       cycles      = 0;
  logic [7:0]               ra [7] = '{`UIQ_A_CFG, `UIQ_A_FILT, `UIQ_A_UNIT, `UIQ_A_FMT, `UIQ_A_ISTAT, `UIQ_A_IMASK, 8'h1C};
  logic [31:0]              rv [7] = '{32'h0000_0007, 32'h0000_0444, 32'h0000_0041, 32'h0000_0053,
                                       32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  always #2.5 CLOCK = ~CLOCK;

  uiq_top i_uiq_top (.CLOCK(CLOCK), .RSTN(RSTN), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .TX_DATA(TX_DATA),
    .TX_VALID(TX_VALID), .TX_READY(TX_READY), .ERR_IN(ERR_IN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .IRQ(IRQ));
  uiq_host_model i_uiq_host_model (.clk(CLOCK), .rx_data(RX_DATA), .rx_valid(RX_VALID), .tx_data(TX_DATA),
    .tx_valid(TX_VALID), .tx_ready(TX_READY));

  // ------------------------------------------------------------
  // bus tasks and line helpers
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLOCK);
    ADDR  <= a;
    WDATA <= v;
    WR    <= 1'b1;
    @(posedge CLOCK);
    WR    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge CLOCK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLOCK);
    RD   <= 1'b0;
    #1 d = RDATA;
  endtask

  function automatic logic [7:0] sum8(input string s);
    logic [7:0] a;
    a = 8'h00;
    foreach (s[i]) a = a + 8'(s[i]);
    return a;
  endfunction

  function automatic string ln(input string b);
    return {b, $sformatf("%0d", sum8(b)), "\015"};
  endfunction

  // send one line, wait a bounded time for the answer, compare it byte by byte
  task automatic q(input string line, input string body);
    string e;
    int    n;
    e = ln(body);
    i_uiq_host_model.got_q.delete();
    i_uiq_host_model.send(line);
    n = 0;
    while (n < 600 && !(i_uiq_host_model.got_q.size() > 0 && i_uiq_host_model.got_q[$] === `UIQ_CH_CR)) begin
      @(posedge CLOCK);
      n++;
    end
    `CHK(i_uiq_host_model.got_q.size(), e.len())
    foreach (e[i]) if (i < i_uiq_host_model.got_q.size()) `CHK(i_uiq_host_model.got_q[i], 8'(e[i]))
  endtask

  task automatic wrap_up();
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // hang guard, well above the roughly one thousand cycles the run needs
  // ------------------------------------------------------------
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    repeat (6) @(posedge CLOCK);
    RSTN <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(ra[i]);
      `CHK(d, rv[i])
    end
    q(ln("$id,"), "#id,0,S,");
    #1;
    `CHK(IRQ, 1'b0)
    wr(`UIQ_A_IMASK, 32'h0000_0001);
    repeat (2) @(posedge CLOCK);
    #1;
    `CHK(IRQ, 1'b1)
    wr(`UIQ_A_ISTAT, 32'h0000_0001);
    wr(`UIQ_A_IMASK, 32'h0000_0000);
    repeat (2) @(posedge CLOCK);
    #1;
    `CHK(IRQ, 1'b0)
    rd(`UIQ_A_ISTAT);
    `CHK(d, 32'h0000_0000)
    q(ln("$igu,"), "#igu,0,A,");
    // slow sink: the answer must wait, byte by byte, for ready
    i_uiq_host_model.slow <= 1'b1;
    q(ln("$ifw,"), "#ifw,0,FWCFG-01,");
    q(ln("$ihw,"), "#ihw,0,HWCFG-01,");
    i_uiq_host_model.slow <= 1'b0;
    wr(`UIQ_A_CFG, 32'h0000_0005);
    wr(`UIQ_A_FILT, 32'h0000_04C2);
    q(ln("$iax,"), "#iax,0,XZ,NA,NA,");
    q(ln("$igf,"), "#igf,0,2,NA,4,");
    wr(`UIQ_A_CFG, 32'h0000_0000);
    q(ln("$iax,"), "#iax,0,NA,NA,NA,");
    q(ln("$iconf,t,"), "#iconf,0,T,0,");
    wr(`UIQ_A_CFG, 32'h0000_000F);
    q(ln("$iconf,t,"), "#iconf,0,T,1,");
    q(ln("$iconf,b,"), "#iconf,0,B,0,");
    @(posedge CLOCK);
    ERR_IN <= 80'h8000_0000_0000_0000_0004;
    @(posedge CLOCK);
    ERR_IN <= '0;
    q(ln("$ie,"), "#ie,0,128,0,0,0,0,0,0,0,0,4,0,0,0,0,0,0,");
    q(ln("$ie,"), "#ie,0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,");
    rd(`UIQ_A_ISTAT);
    `CHK(d[2], 1'b1)
    wr(`UIQ_A_ISTAT, 32'h0000_0007);
    q("id,0\015", "#,1,");
    q({"$id,", $sformatf("%0d", sum8("$id,") + 8'h01), "\015"}, "#,2,");
    rd(`UIQ_A_LAST);
    `CHK(d[3:0], 4'h2)
    rd(`UIQ_A_ISTAT);
    `CHK(d[1:0], 2'h3)
    q(ln("$ix,"), "#,3,");
    q(ln("$id,x,"), "#id,4,");
    q(ln("$iconf,q,"), "#iconf,5,");
    q({"$iconf,q,", $sformatf("%0d", sum8("$iconf,q,") + 8'h01), "\015"}, "#,2,");
    wr(`UIQ_A_FMT, 32'h0000_0042);
    q(ln("$id,"), "#id,0,B,");
    wrap_up();
  end
endmodule // uiq_top_test
